// ==== shared/ehc_pkg.sv ====
// ehc_pkg: constants for the host command register block
// assumes a 32-bit register access port and a 100 MHz system clock
package ehc_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0]  HOST_COMMAND_OFFSET = 8'h20;   // byte offset in operational set
  localparam logic [31:0] HOST_COMMAND_RESET  = 32'h0008_0000;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int RUN_STOP_BIT     = 0;
  localparam int CTRL_RESET_BIT   = 1;
  localparam int FRAME_SIZE_LO    = 2;
  localparam int FRAME_SIZE_HI    = 3;
  localparam int PERIODIC_EN_BIT  = 4;
  localparam int ASYNC_EN_BIT     = 5;
  localparam int DOORBELL_BIT     = 6;
  localparam int LIGHT_RESET_BIT  = 7;
  localparam int THRESH_LO        = 16;
  localparam int THRESH_HI        = 23;

  // --------------------------------------------------------------
  // reset values and threshold encodings
  // --------------------------------------------------------------
  localparam logic [7:0] THRESH_RESET = 8'h08;
  localparam logic [7:0] THRESH_1     = 8'h01;
  localparam logic [7:0] THRESH_2     = 8'h02;
  localparam logic [7:0] THRESH_4     = 8'h04;
  localparam logic [7:0] THRESH_8     = 8'h08;
  localparam logic [7:0] THRESH_16    = 8'h10;
  localparam logic [7:0] THRESH_32    = 8'h20;
  localparam logic [7:0] THRESH_64    = 8'h40;

  // --------------------------------------------------------------
  // timing: one micro frame is 125 us
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int UFRAME_NS        = 125000;
  localparam int UFRAME_CYCLES    = (UFRAME_NS * 1000) / CLK_PERIOD_PS;
  localparam int LIGHT_RESET_NS   = 1000;
  localparam int LIGHT_RESET_CYC  = (LIGHT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ==== hdl/ehc_uframe_pacer.sv ====
// ehc_uframe_pacer: micro frame tick and interrupt threshold pacing
// assumes the tick divider and pending input are on clk_sys
`timescale 1ns/1ps
`default_nettype none
module ehc_uframe_pacer #(
  parameter int UFRAME_CYC = ehc_pkg::UFRAME_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,          // counting only while running
  input  wire logic [7:0] threshold,    // micro frames per period
  input  wire logic       pend_set,     // new interrupt cause this cycle
  output logic            uframe_tick,  // one cycle per micro frame
  output logic            irq_release   // one cycle at period boundary
);
  import ehc_pkg::*;

  // elaboration check: the divider needs two cycles per micro frame
  if (UFRAME_CYC < 2) begin
    $error("UFRAME_CYC too small");
  end

  localparam int DW = $clog2(UFRAME_CYC);

  logic [DW-1:0] div_q;     // micro frame divider
  logic [7:0]    uf_q;      // micro frames into this period
  logic          pend_q;    // accumulated causes
  logic          boundary;  // last micro frame of period ends now

  // --------------------------------------------------------------
  // micro frame divider
  // --------------------------------------------------------------
  assign uframe_tick = run && (div_q == DW'(UFRAME_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      div_q <= '0;
    end else if (uframe_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // --------------------------------------------------------------
  // period counter: restarts from each boundary
  // --------------------------------------------------------------
  assign boundary = uframe_tick && ((uf_q + 8'h01) >= threshold);

  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      uf_q <= '0;
    end else if (boundary) begin
      uf_q <= '0;
    end else if (uframe_tick) begin
      uf_q <= uf_q + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // causes wait for the boundary; a set in the release cycle is kept
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (pend_set) begin
      pend_q <= 1'b1;
    end else if (boundary) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_release <= 1'b0;
    end else begin
      irq_release <= boundary && pend_q;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/ehc_host_command.sv ====
// ehc_host_command: host command register with command side effects
// assumes a simple 32-bit register access port on clk_sys, and a
// schedule engine that reports async cache eviction
//
// Overview of operation
// - each write acts on new control values
// - bits 7..0 hold control fields
// - threshold bits 23:16, reset value 0x00080000
// - threshold paces interrupt delivery
// - thresholds 1,2,4,8,16,32 micro frames accepted
// - threshold 40h, 64 micro frames accepted
// - doorbell: flag set, then doorbell clears
// - light reset reads one while busy
`timescale 1ns/1ps
`default_nettype none
module ehc_host_command #(
  parameter int UFRAME_CYC = ehc_pkg::UFRAME_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,        // byte offset
  input  wire logic        reg_wr,          // write strobe
  input  wire logic        reg_rd,          // read strobe
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,       // registered read data
  input  wire logic        async_evicted,   // schedule engine: cache flushed
  input  wire logic        async_advanced_irq_enable,
  input  wire logic        other_irq_pending, // other status causes
  output logic             run_stop,
  output logic             controller_reset,
  output logic [1:0]       frame_list_size,
  output logic             periodic_schedule_enable,
  output logic             async_schedule_enable,
  output logic             async_doorbell_req, // doorbell pending to engine
  output logic             light_reset_busy,
  output logic [7:0]       interrupt_threshold,
  output logic             controller_halted,
  output logic             async_advanced_flag,
  output logic             uframe_tick,
  output logic             irq_out
);
  import ehc_pkg::*;

  // elaboration check: the divider needs two cycles per micro frame
  if (UFRAME_CYC < 2) begin
    $error("UFRAME_CYC too small");
  end

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic       run_q;          // run/stop
  logic       hcr_q;          // controller reset in progress
  logic [1:0] frame_size_q;   // frame list size field
  logic       periodic_en_q;  // periodic schedule enable
  logic       async_en_q;     // async schedule enable
  logic       bell_q;         // doorbell bit
  logic       lrst_q;         // light reset in progress
  logic [7:0] thresh_q;       // interrupt threshold field
  logic [7:0] lrst_cnt_q;     // light reset duration counter
  logic       adv_flag_q;     // advance flag, sticky
  logic       evict_seen_q;   // flag was set by an eviction last cycle
  logic       halted_q;       // controller halted
  logic       wr_cmd;         // write hits the command register
  logic       thresh_ok;      // written threshold is an accepted code
  logic       adv_event;      // eviction answers a rung doorbell
  logic       irq_cause;      // any cause for the pacer this cycle
  logic       irq_rel;        // pacer releases held causes

  // only the command offset is decoded; other offsets live elsewhere
  assign wr_cmd = reg_wr && (reg_addr == HOST_COMMAND_OFFSET);

  // accepted threshold encodings; others are ignored to stay defined
  always_comb begin
    case (reg_wdata[THRESH_HI:THRESH_LO])
      THRESH_1, THRESH_2, THRESH_4, THRESH_8, THRESH_16, THRESH_32: begin
        thresh_ok = 1'b1;
      end
      THRESH_64: begin
        thresh_ok = 1'b1;
      end
      default: begin
        thresh_ok = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // control fields: a write takes effect at once
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || hcr_q) begin
      run_q         <= 1'b0;
      frame_size_q  <= 2'h0;
      periodic_en_q <= 1'b0;
      async_en_q    <= 1'b0;
      thresh_q      <= THRESH_RESET;
    end else if (wr_cmd) begin
      run_q         <= reg_wdata[RUN_STOP_BIT];
      frame_size_q  <= reg_wdata[FRAME_SIZE_HI:FRAME_SIZE_LO];
      periodic_en_q <= reg_wdata[PERIODIC_EN_BIT];
      async_en_q    <= reg_wdata[ASYNC_EN_BIT];
      if (thresh_ok) begin
        thresh_q <= reg_wdata[THRESH_HI:THRESH_LO];
      end
    end
  end

  // controller reset self-clears one cycle after the write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hcr_q <= 1'b0;
    end else if (hcr_q) begin
      hcr_q <= 1'b0;
    end else begin
      hcr_q <= wr_cmd && reg_wdata[CTRL_RESET_BIT];
    end
  end

  // light reset: busy for a fixed time, then reads zero
  // a second request while busy is dropped rather than stretching the time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lrst_q     <= 1'b0;
      lrst_cnt_q <= 8'h00;
    end else if (wr_cmd && reg_wdata[LIGHT_RESET_BIT] && !lrst_q) begin
      lrst_q     <= 1'b1;
      lrst_cnt_q <= 8'(LIGHT_RESET_CYC - 1);
    end else if (lrst_q) begin
      if (lrst_cnt_q == 8'h00) begin
        lrst_q <= 1'b0;
      end else begin
        lrst_cnt_q <= lrst_cnt_q - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------
  // doorbell and advance flag
  // --------------------------------------------------------------
  // an eviction only counts while the doorbell is rung
  assign adv_event = bell_q && async_evicted;

  // doorbell drops the cycle after the flag is set; a fresh ring in that
  // same cycle wins, so a request from software in that cycle is not lost
  always_ff @(posedge clk_sys) begin
    if (rst || hcr_q) begin
      bell_q <= 1'b0;
    end else if (wr_cmd && reg_wdata[DOORBELL_BIT]) begin
      bell_q <= 1'b1;
    end else if (evict_seen_q) begin
      bell_q <= 1'b0;
    end
  end

  // clear pulse for the doorbell: the flag is sticky, so it cannot
  // serve as the clear condition of a later ring
  always_ff @(posedge clk_sys) begin
    if (rst || hcr_q) begin
      evict_seen_q <= 1'b0;
    end else begin
      evict_seen_q <= adv_event;
    end
  end

  // advance flag: only rst and controller reset clear it here, the status side owns other clears
  always_ff @(posedge clk_sys) begin
    if (rst || hcr_q) begin
      adv_flag_q <= 1'b0;
    end else if (adv_event) begin
      adv_flag_q <= 1'b1;
    end
  end

  // halted follows run/stop with one cycle lag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      halted_q <= 1'b1;
    end else begin
      halted_q <= !run_q;
    end
  end

  // --------------------------------------------------------------
  // interrupt pacing
  // --------------------------------------------------------------
  // advance cause only when its enable is set; other causes always count
  assign irq_cause = (adv_event && async_advanced_irq_enable) || other_irq_pending;

  ehc_uframe_pacer #(
    .UFRAME_CYC (UFRAME_CYC)
  ) u_pacer (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .run         (run_q),
    .threshold   (thresh_q),
    .pend_set    (irq_cause),
    .uframe_tick (uframe_tick),
    .irq_release (irq_rel)
  );

  // extra stage keeps the interrupt pin a clean flop output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_rel;
    end
  end

  // --------------------------------------------------------------
  // read data, reserved bits zero
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == HOST_COMMAND_OFFSET) begin
      reg_rdata <= {8'h00, thresh_q, 8'h00, lrst_q, bell_q, async_en_q, periodic_en_q,
                    frame_size_q, hcr_q, run_q};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // field outputs straight from their flops
  assign run_stop                 = run_q;
  assign controller_reset         = hcr_q;
  assign frame_list_size          = frame_size_q;
  assign periodic_schedule_enable = periodic_en_q;
  assign async_schedule_enable    = async_en_q;
  assign async_doorbell_req       = bell_q;
  assign light_reset_busy         = lrst_q;
  assign interrupt_threshold      = thresh_q;
  assign controller_halted        = halted_q;
  assign async_advanced_flag      = adv_flag_q;

endmodule
`default_nettype wire

// ==== verif/ehc_engine_model.sv ====
// ehc_engine_model: schedule engine stand-in that answers the doorbell
// assumes the doorbell request is a level held until the flag is set
`timescale 1ns/1ps
`default_nettype none
module ehc_engine_model #(
  parameter int DELAY = 6  // flush time in cycles
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_doorbell_req,
  output logic      async_evicted
);
  int cnt;  // cycles since the ring
  // one pulse per ring; the count parks so a slow clear cannot re-fire it
  always_ff @(posedge clk_sys) begin
    if (rst || !async_doorbell_req) begin
      cnt           <= 0;
      async_evicted <= 1'b0;
    end else begin
      cnt           <= (cnt > DELAY) ? cnt : cnt + 1;
      async_evicted <= (cnt == DELAY);
    end
  end
endmodule
`default_nettype wire

// ==== verif/ehc_host_command_assertions.sv ====
// ehc_host_command_assertions: port checks of the host command register
// assumes one clk_sys domain and the synchronous rst of the design
`timescale 1ns/1ps
`default_nettype none
module ehc_host_command_assertions #(
  parameter int UFRAME_CYC = 4  // micro frame length, unused here
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        async_evicted,
  input wire logic        async_doorbell_req,
  input wire logic        async_advanced_flag,
  input wire logic        run_stop,
  input wire logic        controller_halted,
  input wire logic        controller_reset,
  input wire logic [7:0]  interrupt_threshold,
  input wire logic        light_reset_busy,
  input wire logic        uframe_tick,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // plain write: no reset bits, so the fields must follow the data
  wire logic wcmd = reg_wr && reg_addr == 8'h20 && !reg_wdata[1] && !reg_wdata[7]
                    && !light_reset_busy;
  sequence s_evict; async_doorbell_req && async_evicted; endsequence
  sequence s_adv; async_advanced_flag ##1 !async_doorbell_req; endsequence
  chk_read_map: assert property (reg_rd && reg_addr == 8'h20 && !reg_wr && !controller_reset
    |=> reg_rdata[23:16] == interrupt_threshold && reg_rdata[0] == run_stop)
    else $error("read data differs from fields");
  chk_write_run: assert property (wcmd |=> run_stop == $past(reg_wdata[0]))
    else $error("run bit not taken");
  chk_thresh_valid: assert property (wcmd && $onehot(reg_wdata[23:16]) && !reg_wdata[23]
    |=> interrupt_threshold == $past(reg_wdata[23:16])) else $error("threshold not taken");
  chk_doorbell_seq: assert property (s_evict |=> s_adv)
    else $error("doorbell order broken");
  chk_halt_follow: assert property (run_stop |=> !controller_halted)
    else $error("halted while running");
  // release flop plus output flop: the tick stands two cycles back
  chk_irq_paced: assert property (irq_out |-> $past(uframe_tick, 2))
    else $error("interrupt off boundary");
  chk_reset_pulse: assert property (controller_reset |=> !controller_reset
    && interrupt_threshold == 8'h08 && !run_stop) else $error("controller reset wrong");
  chk_light_busy: assert property (reg_wr && reg_addr == 8'h20 && reg_wdata[7]
    && !reg_wdata[1] && !light_reset_busy |=> light_reset_busy[*8])
    else $error("light reset not busy");
endmodule
bind ehc_host_command ehc_host_command_assertions #(.UFRAME_CYC(UFRAME_CYC)) chk_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .async_evicted(async_evicted),
  .async_doorbell_req(async_doorbell_req), .async_advanced_flag(async_advanced_flag),
  .run_stop(run_stop), .controller_halted(controller_halted),
  .controller_reset(controller_reset), .interrupt_threshold(interrupt_threshold),
  .light_reset_busy(light_reset_busy), .uframe_tick(uframe_tick), .irq_out(irq_out));
`default_nettype wire

// ==== verif/tb_ehc_host_command.sv ====
// tb_ehc_host_command: register tests of the host command block
// assumes ehc_pkg, the design, the checker and the engine model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_ehc_host_command;
  import ehc_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        other_irq = 1'b0;  // other interrupt cause
  logic        evicted, run, bell, lbusy, halted, flag, irq, hcr, tick;
  logic [1:0]  fsize;
  logic        per_en, asy_en;
  logic [7:0]  thresh;
  logic [7:0]  vals [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
  int          n_errors = 0, n_checks = 0, cyc = 0, n_tick = 0;
  always #5 clk_sys = ~clk_sys;  // 100 MHz
  ehc_host_command #(.UFRAME_CYC(4)) ehc_host_command_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .async_evicted(evicted),
    .async_advanced_irq_enable(irq_en), .other_irq_pending(other_irq), .run_stop(run),
    .controller_reset(hcr), .frame_list_size(fsize), .periodic_schedule_enable(per_en),
    .async_schedule_enable(asy_en), .async_doorbell_req(bell), .light_reset_busy(lbusy),
    .interrupt_threshold(thresh), .controller_halted(halted), .async_advanced_flag(flag),
    .uframe_tick(tick), .irq_out(irq));
  ehc_engine_model #(.DELAY(6)) ehc_engine_model_inst (
    .clk_sys(clk_sys), .rst(rst), .async_doorbell_req(bell), .async_evicted(evicted));
  // bus cycles: drive on the falling edge, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    v = reg_rdata;  // data stands for this one cycle only
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h20, d);
    `CHK("reset value", 32'h0008_0000, d)
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, d);
    `CHK("unmapped", 32'h0, d)
    rd(8'h20, d);
    `CHK("kept", 32'h0008_0000, d)
    foreach (vals[i]) begin
      wr(8'h20, {8'h00, vals[i], 16'h0000});
      rd(8'h20, d);
      `CHK("threshold", {8'h00, vals[i], 16'h0000}, d)
    end
    // software side: legal threshold codes only, written while halted
    wr(8'h20, 32'h0040_003C);
    rd(8'h20, d);
    `CHK("field word", 32'h0040_003C, d)
    `CHK("fields", 4'hF, {asy_en, per_en, fsize})
    `CHK("threshold out", 8'h40, thresh)
    irq_en = 1'b1;
    wr(8'h20, 32'h0001_0041);
    for (int i = 0; i < 100 && flag !== 1'b1; i++) @(negedge clk_sys);
    `CHK("flag", 1'b1, flag)
    `CHK("bell held", 1'b1, bell)
    @(negedge clk_sys);
    `CHK("bell clear", 1'b0, bell)
    for (int i = 0; i < 50 && irq !== 1'b1; i++) @(negedge clk_sys);
    `CHK("irq", 1'b1, irq)
    `CHK("running", 1'b0, halted)
    `CHK("run bit", 1'b1, run)
    // a cause from elsewhere is held and leaves at the next boundary
    @(negedge clk_sys);
    other_irq = 1'b1;
    @(negedge clk_sys);
    other_irq = 1'b0;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk_sys);
    `CHK("other irq", 1'b1, irq)
    // one micro frame tick per 4 cycles while running
    repeat (20) begin
      @(negedge clk_sys);
      if (tick === 1'b1) begin
        n_tick++;
      end
    end
    `CHK("ticks", 32'h0000_0005, n_tick)
    wr(8'h20, 32'h0001_0000);
    @(negedge clk_sys);
    `CHK("halted", 1'b1, halted)
    wr(8'h20, 32'h0020_0002);
    `CHK("reset pulse", 1'b1, hcr)
    repeat (3) @(negedge clk_sys);
    `CHK("reset done", 1'b0, hcr)
    rd(8'h20, d);
    `CHK("ctrl reset", 32'h0008_0000, d)
    `CHK("flag cleared", 1'b0, flag)
    wr(8'h20, 32'h0008_0080);
    rd(8'h20, d);
    `CHK("light busy", 1'b1, d[7])
    for (int i = 0; i < 300 && lbusy !== 1'b0; i++) @(negedge clk_sys);
    rd(8'h20, d);
    `CHK("light done", 1'b0, d[7])
    stop_test();
  end
endmodule
`default_nettype wire
